// >>> design/txg_gearbox.sv
/*
  Transmit synchronous gearbox top: header and payload combining for
  64B/66B and 64B/67B coding, normal single-stream or two-stream CAUI mode.
  CAUI splits the user word in halves, stream A low and stream B high.
  Mode and enable are static parameters. The asynchronous variant is not
  built; selecting it falls back to the straight pass-through path, which
  is also what a disabled gearbox uses.
  Assumes payload is already scrambled and that the user drives its own
  sequence counter and honours o_tx_payload_ready as a hold request.
  Assumes all inputs are synchronous to i_clk and that DATA_W is 16, 32 or
  64; any other width raises o_mode_error rather than stopping the build.
*/
// Operation
// - header bits 1:0 for 66b, 2:0 for 67b
// - CAUI: stream A header 2:0, B 5:3
// - sequence bits 5:0 for 66b, 6:0 for 67b
// - CAUI: one count serves both lanes
// - mode bit 4 selects async gearbox
// - mode bit 2 selects CAUI mode
// - mode bit 0: 1 is 66b, 0 67b
// - gearbox runs only when enabled
// - transmit and receive share one mode
// - user payload width 2, 4 or 8 bytes
// - header merged with payload into coded blocks
`timescale 1ns/1ps
module txg_gearbox #(
  parameter int unsigned             DATA_W       = 32,
  parameter logic [txg_pkg::MODE_W-1:0] GEARBOX_MODE = txg_pkg::MODE_DEFAULT,
  parameter bit                      GEARBOX_EN   = 1'b1
) (
  // clock and reset
  input  wire logic                             i_clk,
  input  wire logic                             i_rst_b,
  // user side
  input  wire logic [txg_pkg::PAYLOAD_IN_W-1:0] i_tx_payload_in,
  input  wire logic [txg_pkg::HDR_IN_W-1:0]     i_tx_block_header_in,
  input  wire logic [txg_pkg::SEQ_IN_W-1:0]     i_tx_seq_count_in,
  output logic                                  o_tx_payload_ready,
  // line side
  output logic      [DATA_W-1:0]                o_tx_line_data,
  output logic                                  o_tx_line_valid,
  // per-lane sequence count and status
  output logic      [txg_pkg::SEQ_IN_W-1:0]     o_pcs_lane_a_seq,
  output logic      [txg_pkg::SEQ_IN_W-1:0]     o_pcs_lane_b_seq,
  output logic                                  o_tx_gearbox_active,
  output logic                                  o_mode_error
);
  import txg_pkg::*;

  // static decode of the shared mode setting; the receive side reads the same
  // value, so there is no separate receive mode to keep consistent
  localparam bit ASYNC_SEL = GEARBOX_MODE[MODE_ASYNC];
  localparam bit CAUI_SEL  = GEARBOX_MODE[MODE_CAUI];
  localparam bit CODE66    = GEARBOX_MODE[MODE_CODE66];
  localparam bit UNUSED_SET = GEARBOX_MODE[MODE_UNUSED_3] | GEARBOX_MODE[MODE_UNUSED_1];
  // async variant is not built here, so only the sync path can run
  localparam bit RUN_SYNC  = GEARBOX_EN && !ASYNC_SEL;
  // 67b coding with the async gearbox is an illegal pairing
  localparam bit MODE_BAD  = UNUSED_SET || (ASYNC_SEL && !CODE66);
  localparam logic [SEQ_IN_W-1:0] SEQ_MASK = CODE66 ? SEQ66_MASK : SEQ67_MASK;

  // only documented user widths are legal; a bad width is reported, not stopped
  localparam bit WIDTH_BAD = (DATA_W != 16) && (DATA_W != 32) && (DATA_W != 64);

  logic [SEQ_IN_W-1:0] seq_a_reg;
  logic [SEQ_IN_W-1:0] seq_b_reg;
  logic                active_reg;
  logic                mode_err_reg;
  logic                lane_skew;
  logic                skew_reg;

  // one count input feeds both lanes, masked to the coding's width
  // each lane keeps its own copy so lane outputs never share a flop
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seq_a_reg <= SEQ_RST;
    end else if (RUN_SYNC) begin
      seq_a_reg <= i_tx_seq_count_in & SEQ_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seq_b_reg <= SEQ_RST;
    end else if (RUN_SYNC) begin
      seq_b_reg <= i_tx_seq_count_in & SEQ_MASK;
    end
  end

  // status is static but still leaves a flop, so it reads 0 during reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= RUN_SYNC;
    end
  end

  // sticky: once the two CAUI lanes drift apart every later word is suspect
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      skew_reg <= 1'b0;
    end else if (lane_skew) begin
      skew_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_err_reg <= 1'b0;
    end else begin
      mode_err_reg <= MODE_BAD || WIDTH_BAD || skew_reg;
    end
  end

  // the assigns only rename flop outputs
  assign o_pcs_lane_a_seq    = seq_a_reg;
  assign o_pcs_lane_b_seq    = seq_b_reg;
  assign o_tx_gearbox_active = active_reg;
  assign o_mode_error        = mode_err_reg;

  if (!RUN_SYNC) begin : g_bypass
    // header and count are ignored; payload goes out one edge later
    logic [DATA_W-1:0] pass_reg;
    logic              pass_vld_reg;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        pass_reg     <= '0;
        pass_vld_reg <= 1'b0;
      end else begin
        pass_reg     <= i_tx_payload_in[DATA_W-1:0];
        pass_vld_reg <= 1'b1;
      end
    end

    // the straight path never pauses, so ready stays up after reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        o_tx_payload_ready <= 1'b0;
      end else begin
        o_tx_payload_ready <= 1'b1;
      end
    end

    assign o_tx_line_data  = pass_reg;
    assign o_tx_line_valid = pass_vld_reg;
    assign lane_skew       = 1'b0;

  end else if (CAUI_SEL) begin : g_caui
    // two streams, each carried on half the user width
    localparam int unsigned HW = DATA_W / 2;
    logic [HW-1:0] dat_a;
    logic [HW-1:0] dat_b;
    logic          vld_a;
    logic          vld_b;
    logic          take_a;
    logic          take_b;
    logic [2:0]    hdr_b;

    // 66b CAUI: stream B bit 2 is forced low even if the user misdrives it
    assign hdr_b = CODE66 ? {1'b0, i_tx_block_header_in[HDR_B_LSB+1:HDR_B_LSB]}
                          : i_tx_block_header_in[HDR_IN_W-1:HDR_B_LSB];

    txg_lane #(.CW(HW)) u_lane_a (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_chunk (i_tx_payload_in[HW-1:0]),
      .i_hdr   (i_tx_block_header_in[HDR_MAX_W-1:0]),
      .i_hdr67 (!CODE66),
      .o_data  (dat_a),
      .o_valid (vld_a),
      .o_take  (take_a)
    );

    // stream B rides the upper half of the user word
    txg_lane #(.CW(HW)) u_lane_b (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_chunk (i_tx_payload_in[DATA_W-1:HW]),
      .i_hdr   (hdr_b),
      .i_hdr67 (!CODE66),
      .o_data  (dat_b),
      .o_valid (vld_b),
      .o_take  (take_b)
    );

    // equal block lengths keep the lanes in lockstep, so lane A speaks for
    // both; any disagreement is latched into the mode error instead
    assign lane_skew          = (take_a != take_b) || (vld_a != vld_b);
    assign o_tx_payload_ready = take_a;
    assign o_tx_line_data     = {dat_b, dat_a};
    assign o_tx_line_valid    = vld_a;

  end else begin : g_normal
    // one lane carries the whole user word, so its hold request is the block's
    logic take;

    txg_lane #(.CW(DATA_W)) u_lane (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_chunk (i_tx_payload_in[DATA_W-1:0]),
      .i_hdr   (i_tx_block_header_in[HDR_MAX_W-1:0]),
      .i_hdr67 (!CODE66),
      .o_data  (o_tx_line_data),
      .o_valid (o_tx_line_valid),
      .o_take  (take)
    );

    assign o_tx_payload_ready = take;
    assign lane_skew          = 1'b0;
  end

endmodule

// >>> design/txg_lane.sv
/*
  One gearbox lane: merges a header with the first chunk of each 64-bit block
  and repacks the resulting 66/67-bit blocks into fixed-width line words.
  Assumes the user holds its chunk whenever o_take was low for that cycle.
*/
`timescale 1ns/1ps
module txg_lane #(
  parameter int unsigned CW = 32
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  // user side
  input  wire logic [CW-1:0] i_chunk,
  input  wire logic [2:0]    i_hdr,
  input  wire logic          i_hdr67,
  // line side
  output logic      [CW-1:0] o_data,
  output logic               o_valid,
  output logic               o_take
);
  import txg_pkg::*;

  localparam int unsigned ACC = 2 * CW + 4;
  localparam int unsigned LW  = $clog2(ACC + 1);
  localparam int unsigned CPB = BLOCK_PAY_W / CW;
  localparam int unsigned IW  = (CPB > 1) ? $clog2(CPB) : 1;
  localparam logic [LW-1:0] CW_L   = LW'(CW);
  localparam logic [LW-1:0] ROOM_L = LW'(CW + 1);
  localparam logic [IW-1:0] LAST_I = IW'(CPB - 1);

  logic [ACC-1:0]  acc_reg;
  logic [LW-1:0]   level_reg;
  logic [IW-1:0]   idx_reg;
  logic            take_reg;

  logic            emit;
  logic [LW-1:0]   lvl_after;
  logic [ACC-1:0]  acc_after;
  logic            first;
  logic [CW+2:0]   new_vec;
  logic [LW-1:0]   new_len;
  logic [ACC-1:0]  acc_next;
  logic [LW-1:0]   level_next;
  logic [LW-1:0]   lvl2;

  always_comb begin
    emit      = level_reg >= CW_L;
    lvl_after = emit ? level_reg - CW_L : level_reg;
    acc_after = emit ? acc_reg >> CW : acc_reg;
    first     = idx_reg == '0;
    // header sits in the low bits so it goes on the wire first
    if (!first) begin
      new_vec = {3'h0, i_chunk};
      new_len = CW_L;
    end else if (i_hdr67) begin
      new_vec = {i_chunk, i_hdr};
      new_len = LW'(CW + HDR67_W);
    end else begin
      new_vec = {1'b0, i_chunk, i_hdr[HDR66_W-1:0]};
      new_len = LW'(CW + HDR66_W);
    end
    acc_next   = take_reg ? (acc_after | (ACC'(new_vec) << lvl_after)) : acc_after;
    level_next = take_reg ? lvl_after + new_len : lvl_after;
    lvl2       = (level_next >= CW_L) ? level_next - CW_L : level_next;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_reg   <= '0;
      level_reg <= '0;
    end else begin
      acc_reg   <= acc_next;
      level_reg <= level_next;
    end
  end

  // block boundary tracking; one header per 64 payload bits
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idx_reg <= '0;
    end else if (take_reg) begin
      idx_reg <= (idx_reg == LAST_I) ? '0 : idx_reg + IW'(1);
    end
  end

  // pause decided a cycle ahead so the hold request leaves a flop
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      take_reg <= READY_RST;
    end else begin
      take_reg <= lvl2 <= ROOM_L;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data  <= '0;
      o_valid <= 1'b0;
    end else begin
      o_data  <= acc_reg[CW-1:0];
      o_valid <= emit;
    end
  end

  assign o_take = take_reg;

endmodule

// >>> inc/txg_pkg.sv
/*
  Shared constants for the transmit synchronous gearbox: mode bit positions,
  header and sequence-count widths per coding, and reset values.
  Assumes a single clock domain and an active-low asynchronous reset.
*/
package txg_pkg;

  // gearbox mode setting, bit positions
  localparam int unsigned MODE_W        = 5;
  localparam int unsigned MODE_ASYNC    = 4;
  localparam int unsigned MODE_UNUSED_3 = 3;
  localparam int unsigned MODE_CAUI     = 2;
  localparam int unsigned MODE_UNUSED_1 = 1;
  localparam int unsigned MODE_CODE66   = 0;

  localparam logic [MODE_W-1:0] MODE_DEFAULT = 5'h01;

  // header field layout
  localparam int unsigned HDR_IN_W      = 6;
  localparam int unsigned HDR_MAX_W     = 3;
  localparam int unsigned HDR66_W       = 2;
  localparam int unsigned HDR67_W       = 3;
  localparam int unsigned HDR_B_LSB     = 3;

  // sequence count layout
  localparam int unsigned SEQ_IN_W      = 7;
  localparam logic [6:0]  SEQ66_MASK    = 7'h3F;
  localparam logic [6:0]  SEQ67_MASK    = 7'h7F;

  // payload
  localparam int unsigned PAYLOAD_IN_W  = 64;
  localparam int unsigned BLOCK_PAY_W   = 64;

  // reset values
  localparam logic [6:0]  SEQ_RST       = 7'h00;
  localparam logic        READY_RST     = 1'b1;

endpackage

// >>> sim/txg_gearbox_sva.sv
/* Port checker for txg_gearbox.
   Assumes static mode parameters and a single clock domain. */
`timescale 1ns/1ps
module txg_gearbox_sva import txg_pkg::*; #(
  parameter int unsigned       DATA_W       = 32,
  parameter logic [MODE_W-1:0] GEARBOX_MODE = MODE_DEFAULT,
  parameter bit                GEARBOX_EN   = 1'b1
) (
  // watched ports
  input wire logic                    i_clk,
  input wire logic                    i_rst_b,
  input wire logic [PAYLOAD_IN_W-1:0] i_tx_payload_in,
  input wire logic [HDR_IN_W-1:0]     i_tx_block_header_in,
  input wire logic [SEQ_IN_W-1:0]     i_tx_seq_count_in,
  input wire logic                    o_tx_payload_ready,
  input wire logic [DATA_W-1:0]       o_tx_line_data,
  input wire logic                    o_tx_line_valid,
  input wire logic [SEQ_IN_W-1:0]     o_pcs_lane_a_seq,
  input wire logic [SEQ_IN_W-1:0]     o_pcs_lane_b_seq,
  input wire logic                    o_tx_gearbox_active,
  input wire logic                    o_mode_error
);
  localparam logic [6:0] SMASK = GEARBOX_MODE[0] ? SEQ66_MASK : SEQ67_MASK;
  localparam bit ACT = GEARBOX_EN && !GEARBOX_MODE[4];
  localparam bit MERR = GEARBOX_MODE[MODE_UNUSED_3] | GEARBOX_MODE[MODE_UNUSED_1]
    | (GEARBOX_MODE[MODE_ASYNC] & !GEARBOX_MODE[MODE_CODE66])
    | ((DATA_W != 16) && (DATA_W != 32) && (DATA_W != 64));
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // $past(i_rst_b) keeps the first edge after release out of reach
  AST_SEQ_MASK: assert property ($past(i_rst_b) && o_tx_gearbox_active |->
    o_pcs_lane_a_seq == ($past(i_tx_seq_count_in) & SMASK)) else $error("seq mask");
  AST_LANES_SAME: assert property (o_tx_gearbox_active |->
    o_pcs_lane_b_seq == o_pcs_lane_a_seq) else $error("lane seq differ");
  AST_ACTIVE: assert property ($past(i_rst_b) |-> o_tx_gearbox_active == ACT)
    else $error("active wrong");
  AST_MODE_ERR: assert property ($past(i_rst_b) |-> o_mode_error == MERR)
    else $error("mode error wrong");
  AST_HOLD_ONE: assert property (o_tx_gearbox_active && !o_tx_payload_ready |=>
    o_tx_payload_ready) else $error("hold too long");
  AST_FILL: assert property (o_tx_gearbox_active && o_tx_payload_ready ##1
    o_tx_payload_ready |=> o_tx_line_valid) else $error("no line word");
  AST_BYP_DATA: assert property ($past(i_rst_b) && !o_tx_gearbox_active |->
    o_tx_line_data == DATA_W'($past(i_tx_payload_in))) else $error("bypass data");
  AST_BYP_VALID: assert property ($past(i_rst_b) && !o_tx_gearbox_active |->
    o_tx_line_valid) else $error("bypass valid");
  cover property (o_tx_gearbox_active && !o_tx_payload_ready);
  cover property ($rose(o_tx_line_valid));
  cover property (!o_tx_gearbox_active && o_tx_line_valid);
endmodule
bind txg_gearbox txg_gearbox_sva #(.DATA_W(DATA_W), .GEARBOX_MODE(GEARBOX_MODE),
  .GEARBOX_EN(GEARBOX_EN)) u_sva (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_tx_payload_in(i_tx_payload_in), .i_tx_block_header_in(i_tx_block_header_in),
  .i_tx_seq_count_in(i_tx_seq_count_in), .o_tx_payload_ready(o_tx_payload_ready),
  .o_tx_line_data(o_tx_line_data), .o_tx_line_valid(o_tx_line_valid),
  .o_pcs_lane_a_seq(o_pcs_lane_a_seq), .o_pcs_lane_b_seq(o_pcs_lane_b_seq),
  .o_tx_gearbox_active(o_tx_gearbox_active), .o_mode_error(o_mode_error));

// >>> sim/txg_gearbox_tb.sv
/* Bench: 66b normal stream checked against a bit queue, plus a bypass copy.
   Assumes txg_user_model drives the user side. */
`timescale 1ns/1ps
module txg_gearbox_tb;
  logic        clk;
  logic        rst_b;
  logic        dirty = 1'b0;
  logic [63:0] pay;
  logic [5:0]  hdr;
  logic [6:0]  seq;
  logic        rdy, dv, act, merr, b_act;
  logic [2:0]  m_act, m_err;
  logic [31:0] dat;
  int          errors = 0;
  int          checks = 0;
  int          words = 0;
  int          idx = 0;
  bit          q[$];
  txg_gearbox #(.DATA_W(32), .GEARBOX_MODE(5'h01), .GEARBOX_EN(1'b1)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_tx_payload_in(pay), .i_tx_block_header_in(hdr),
    .i_tx_seq_count_in(seq), .o_tx_payload_ready(rdy), .o_tx_line_data(dat),
    .o_tx_line_valid(dv), .o_pcs_lane_a_seq(), .o_pcs_lane_b_seq(),
    .o_tx_gearbox_active(act), .o_mode_error(merr));
  txg_gearbox #(.DATA_W(32), .GEARBOX_EN(1'b0)) dut_byp (
    .i_clk(clk), .i_rst_b(rst_b), .i_tx_payload_in(pay), .i_tx_block_header_in(hdr),
    .i_tx_seq_count_in(seq), .o_tx_payload_ready(), .o_tx_line_data(),
    .o_tx_line_valid(), .o_pcs_lane_a_seq(), .o_pcs_lane_b_seq(),
    .o_tx_gearbox_active(b_act), .o_mode_error());
  // extra modes run under the bound checker: 67b, CAUI 66b, async with 67b
  txg_gearbox #(.DATA_W(32), .GEARBOX_MODE(5'h00), .GEARBOX_EN(1'b1)) dut_67 (
    .i_clk(clk), .i_rst_b(rst_b), .i_tx_payload_in(pay), .i_tx_block_header_in(hdr),
    .i_tx_seq_count_in(seq), .o_tx_payload_ready(), .o_tx_line_data(),
    .o_tx_line_valid(), .o_pcs_lane_a_seq(), .o_pcs_lane_b_seq(),
    .o_tx_gearbox_active(m_act[0]), .o_mode_error(m_err[0]));
  txg_gearbox #(.DATA_W(32), .GEARBOX_MODE(5'h05), .GEARBOX_EN(1'b1)) dut_caui (
    .i_clk(clk), .i_rst_b(rst_b), .i_tx_payload_in(pay), .i_tx_block_header_in(hdr),
    .i_tx_seq_count_in(seq), .o_tx_payload_ready(), .o_tx_line_data(),
    .o_tx_line_valid(), .o_pcs_lane_a_seq(), .o_pcs_lane_b_seq(),
    .o_tx_gearbox_active(m_act[1]), .o_mode_error(m_err[1]));
  txg_gearbox #(.DATA_W(32), .GEARBOX_MODE(5'h1A), .GEARBOX_EN(1'b1)) dut_bad (
    .i_clk(clk), .i_rst_b(rst_b), .i_tx_payload_in(pay), .i_tx_block_header_in(hdr),
    .i_tx_seq_count_in(seq), .o_tx_payload_ready(), .o_tx_line_data(),
    .o_tx_line_valid(), .o_pcs_lane_a_seq(), .o_pcs_lane_b_seq(),
    .o_tx_gearbox_active(m_act[2]), .o_mode_error(m_err[2]));
  txg_user_model umod (.i_clk(clk), .i_rst_b(rst_b), .i_ready(rdy), .i_dirty(dirty),
    .o_payload(pay), .o_header(hdr), .o_seq(seq));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // old values at the edge are exactly what the design sampled
  always @(posedge clk) begin
    logic [31:0] w;
    if (rst_b === 1'b1) begin
      if (dv === 1'b1) begin
        for (int i = 0; i < 32; i++) w[i] = q.pop_front();
        check("line_data", dat, w);
        words++;
      end
      if (rdy === 1'b1) begin
        if (idx == 0) for (int i = 0; i < 2; i++) q.push_back(hdr[i]);
        for (int i = 0; i < 32; i++) q.push_back(pay[i]);
        idx = 1 - idx;
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    wrap_up();
  end
  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    check("valid_rst", dv, 0);
    check("active_rst", act, 0);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("active", act, 1);
    check("mode_error", merr, 0);
    check("bypass_active", b_act, 0);
    check("active_67", m_act[0], 1);
    check("error_67", m_err[0], 0);
    check("active_caui", m_act[1], 1);
    check("error_caui", m_err[1], 0);
    check("active_async", m_act[2], 0);
    check("error_async", m_err[2], 1);
    repeat (600) @(posedge clk);
    dirty <= 1'b1;
    repeat (300) @(posedge clk);
    dirty <= 1'b0;
    repeat (300) @(posedge clk);
    check("words", words > 500, 1);
    wrap_up();
  end
endmodule

// >>> sim/txg_user_model.sv
/* User-side model: random payload, 66b headers, block sequence counter.
   Assumes 32-bit user width, so two takes make one block. */
`timescale 1ns/1ps
module txg_user_model (
  // clock, reset, handshake
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ready,
  input  wire logic        i_dirty,
  // user drive
  output logic      [63:0] o_payload,
  output logic      [5:0]  o_header,
  output logic      [6:0]  o_seq
);
  logic [31:0] rnd_reg;
  logic [5:0]  cnt_reg;
  logic        half_reg;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rnd_reg   <= 32'h0000D6BA;
      cnt_reg   <= 6'h00;
      half_reg  <= 1'b0;
      o_payload <= 64'h0;
      o_header  <= 6'h01;
      o_seq     <= 7'h00;
    end else if (i_ready) begin
      rnd_reg   <= xs(xs(rnd_reg));
      // random words stand in for scrambled data
      o_payload <= {xs(xs(rnd_reg)), xs(rnd_reg)};
      // dirty drives the unused bits on purpose
      o_header  <= {i_dirty ? rnd_reg[9:6] : 4'h0, rnd_reg[0], ~rnd_reg[0]};
      half_reg  <= ~half_reg;
      if (half_reg) cnt_reg <= (cnt_reg == 6'h20) ? 6'h00 : cnt_reg + 6'h01;
      o_seq     <= {i_dirty & rnd_reg[10], cnt_reg};
    end
  end
endmodule
